// ---- rtl/flash_guard_regs.svh ----
// register offsets, field positions, reset values and address constants of the flash guard
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH

// special function register offsets
`define TWC_OFFSET        8'hb7
`define CPL_OFFSET        8'hb6

// timing / write control fields
`define TWC_RESET         8'h80
`define TWC_WE_BIT        0
`define TWC_RT_HI         5
`define TWC_RT_LO         4
`define TWC_RSVD_HI       3
`define TWC_RSVD_LO       1
`define TWC_UNUSED_RD     2'h2
`define TWC_RSVD_RD       3'h0
`define RT_RESET          2'h0

// access limit register
`define CPL_RESET         8'h00
`define LIMIT_LOW_ZERO    9'h000

// flash map
`define ADDR_W            17
`define MAP_TOP_ADDR      17'h10000
`define REGION_HI         15
`define REGION_LO         14
`define TOP_REGION_BIT    3
`define LOCK_WR_ADDR      17'h1fbfe
`define LOCK_RD_ADDR      17'h1fbff
`define PAGE_HI           16
`define PAGE_LO           10
`define LOCK_PAGE_IDX     7'h7e
`define RDATA_ZERO        8'h00

`endif

// ---- rtl/flash_guard_pkg.sv ----
// shared types of the flash guard
package flash_guard_pkg;
  typedef enum logic [1:0] {
    op_read,
    op_write,
    op_erase
  } flash_op_e;
endpackage

// ---- rtl/lock_bit_pick.sv ----
// selects the lock bit that guards one 16 kB region of the 64 kB map
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_regs.svh"
module lock_bit_pick (
  // lock byte and address
  input  wire logic [7:0]              lock_byte,
  input  wire logic [`ADDR_W-1:0]      addr,
  // result
  output logic                         in_map,
  output logic                         unlocked
);
  // bits 7..4 guard nothing; addresses past 64 kB never hit them
  always_comb
  begin
    in_map   = (addr < `MAP_TOP_ADDR);
    unlocked = in_map & lock_byte[addr[`REGION_HI:`REGION_LO]];
  end
endmodule
`default_nettype wire

// ---- rtl/flash_access_guard.sv ----
// flash access guard: debug-port lock checks, firmware partition fence, control registers
//
// What the document requires
// RULE_01: each lock bit guards one 16 kB region; the code maps only bits 3..0 onto the 64 kB map, bits 7..4 guard nothing
// RULE_02: read-lock zero blocks debug reads
// RULE_03: write-lock zero blocks debug writes and erases
// RULE_04: top region locked: lock bytes writable, not erasable
// RULE_05: limit is register byte above nine zeros
// RULE_06: limit register takes first write only
// RULE_07: software keeps limit bit 0 clear
// RULE_08: limit resets to zero, all reads open
// RULE_09: upper code reads of lower give junk
// RULE_10: lower-partition code accesses everything freely
// RULE_11: upper code cannot touch pages below limit
// RULE_12: fetches into lower partition always proceed
// RULE_13: lock bytes never restrict firmware accesses
// RULE_14: firmware cannot erase the lock-byte page
// RULE_15: debug may always read, write lock bytes
// RULE_16: debug obeys locks for reads, writes, erases
// RULE_17: unlocked lock page debug-erase resets locks
// RULE_18: full device erase clears everything, unlocks
// RULE_19: software picks smallest legal read-time code
// RULE_20: firmware write/erase needs write-erase allow set
// RULE_21: control bits 3..1 read zero, written zero
// RULE_22: software quiets cache before lowering read time
// RULE_23: debug erase of lock byte starts full erase
// RULE_24: lock bytes sit at two top addresses
// RULE_25: partition test uses executing instruction address
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_regs.svh"
module flash_access_guard (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  // special function register port
  input  wire logic [7:0]                sfr_addr,
  input  wire logic                      sfr_wr,
  input  wire logic                      sfr_rd,
  input  wire logic [7:0]                sfr_wdata,
  output logic [7:0]                     sfr_rdata,
  // lock bytes as stored in flash
  input  wire logic [7:0]                lock_wr_byte,
  input  wire logic [7:0]                lock_rd_byte,
  // debug port requests
  input  wire logic                      dbg_req,
  input  wire flash_guard_pkg::flash_op_e dbg_op,
  input  wire logic [`ADDR_W-1:0]        dbg_addr,
  output logic                           dbg_grant,
  output logic                           dbg_deny,
  output logic                           dbg_full_erase,
  // firmware data-path requests
  input  wire logic                      core_req,
  input  wire flash_guard_pkg::flash_op_e core_op,
  input  wire logic [`ADDR_W-1:0]        core_addr,
  input  wire logic [`ADDR_W-1:0]        core_pc,
  output logic                           core_grant,
  output logic                           core_deny,
  output logic                           core_rdata_blank,
  // instruction fetch
  input  wire logic                      fetch_req,
  output logic                           fetch_grant,
  // flash timing
  output logic [1:0]                     read_time_code
);

  logic [7:0]              code_protect_limit_r;
  logic                    limit_taken_r;
  logic [1:0]              read_time_code_r;
  logic                    write_erase_allow_r;
  logic [7:0]              sfr_rdata_r;
  logic                    dbg_grant_r;
  logic                    dbg_deny_r;
  logic                    dbg_full_erase_r;
  logic                    core_grant_r;
  logic                    core_deny_r;
  logic                    core_rdata_blank_r;
  logic                    fetch_grant_r;
  logic [`ADDR_W-1:0]      partition_limit_address;
  logic                    rd_in_map;
  logic                    rd_open;
  logic                    wr_in_map;
  logic                    wr_open;
  logic                    dbg_lockbyte_hit;
  logic                    dbg_lock_page;
  logic                    top_open;
  logic                    dbg_ok;
  logic                    dbg_full_nxt;
  logic                    core_upper;
  logic                    core_below;
  logic                    core_fence;
  logic                    core_lock_page;
  logic                    core_ok;
  logic                    twc_sel;
  logic                    cpl_sel;

  assign twc_sel = (sfr_addr == `TWC_OFFSET);
  assign cpl_sel = (sfr_addr == `CPL_OFFSET);

  // limit falls on 512-byte steps; low bits forced to zero
  assign partition_limit_address = {code_protect_limit_r, `LIMIT_LOW_ZERO}; // RULE_05

  // access limit: write-once after reset, zero means everything readable
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      code_protect_limit_r <= `CPL_RESET; // RULE_08
      limit_taken_r        <= 1'b0;
    end
    else if (sfr_wr && cpl_sel && !limit_taken_r)
    begin
      code_protect_limit_r <= sfr_wdata; // RULE_06
      limit_taken_r        <= 1'b1;
    end
  end

  // timing / write control; reserved bits are not stored at all
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      read_time_code_r    <= `RT_RESET;
      write_erase_allow_r <= 1'b0;
    end
    else if (sfr_wr && twc_sel)
    begin
      read_time_code_r    <= sfr_wdata[`TWC_RT_HI:`TWC_RT_LO];
      write_erase_allow_r <= sfr_wdata[`TWC_WE_BIT];
    end
  end

  // registered read data; unmapped offsets read zero
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      sfr_rdata_r <= `RDATA_ZERO;
    else if (sfr_rd)
    begin
      if (twc_sel)
        sfr_rdata_r <= {`TWC_UNUSED_RD, read_time_code_r, `TWC_RSVD_RD,
                        write_erase_allow_r}; // RULE_21
      else if (cpl_sel)
        sfr_rdata_r <= code_protect_limit_r;
      else
        sfr_rdata_r <= `RDATA_ZERO;
    end
  end

  // region lookups for debug accesses
  lock_bit_pick u_rd_pick (
    .lock_byte (lock_rd_byte),
    .addr      (dbg_addr),
    .in_map    (rd_in_map),
    .unlocked  (rd_open)
  ); // RULE_01
  lock_bit_pick u_wr_pick (
    .lock_byte (lock_wr_byte),
    .addr      (dbg_addr),
    .in_map    (wr_in_map),
    .unlocked  (wr_open)
  );

  // lock bytes and their page sit above the 64 kB lockable map
  assign dbg_lockbyte_hit = (dbg_addr == `LOCK_WR_ADDR) || (dbg_addr == `LOCK_RD_ADDR); // RULE_24
  assign dbg_lock_page    = (dbg_addr[`PAGE_HI:`PAGE_LO] == `LOCK_PAGE_IDX);
  assign top_open         = lock_wr_byte[`TOP_REGION_BIT];

  // debug decision; an erase aimed at a lock byte always escalates
  always_comb
  begin
    dbg_ok       = 1'b0;
    dbg_full_nxt = 1'b0;
    unique case (dbg_op)
      flash_guard_pkg::op_read:
        dbg_ok = dbg_lockbyte_hit | rd_open; // RULE_02 RULE_15 RULE_16
      flash_guard_pkg::op_write:
        dbg_ok = dbg_lockbyte_hit | wr_open | (dbg_lock_page & top_open); // RULE_03 RULE_15
      flash_guard_pkg::op_erase:
      begin
        if (dbg_lockbyte_hit)
        begin
          dbg_ok       = 1'b1; // RULE_18
          dbg_full_nxt = 1'b1; // RULE_23
        end
        else if (dbg_lock_page)
          dbg_ok = top_open; // RULE_04 RULE_17
        else
          dbg_ok = wr_open; // RULE_03 RULE_16
      end
      default:
        dbg_ok = 1'b0;
    endcase
  end

  // debug answers, one cycle after the request
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dbg_grant_r      <= 1'b0;
      dbg_deny_r       <= 1'b0;
      dbg_full_erase_r <= 1'b0;
    end
    else
    begin
      dbg_grant_r      <= dbg_req & dbg_ok;
      dbg_deny_r       <= dbg_req & ~dbg_ok;
      dbg_full_erase_r <= dbg_req & dbg_full_nxt;
    end
  end

  // firmware side never looks at the lock bytes
  assign core_upper     = (core_pc >= partition_limit_address); // RULE_25
  assign core_below     = (core_addr < partition_limit_address);
  assign core_fence     = core_upper & core_below; // RULE_10 RULE_11
  assign core_lock_page = (core_addr[`PAGE_HI:`PAGE_LO] == `LOCK_PAGE_IDX);

  // firmware decision; no path here can start a full erase
  always_comb
  begin
    core_ok = 1'b0;
    unique case (core_op)
      flash_guard_pkg::op_read:
        core_ok = ~core_fence; // RULE_09 RULE_13
      flash_guard_pkg::op_write:
        core_ok = write_erase_allow_r & ~core_fence; // RULE_20 RULE_14
      flash_guard_pkg::op_erase:
        core_ok = write_erase_allow_r & ~core_fence & ~core_lock_page; // RULE_14 RULE_20
      default:
        core_ok = 1'b0;
    endcase
  end

  // firmware answers; a fenced read is denied, and also flagged with blanked data
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_grant_r       <= 1'b0;
      core_deny_r        <= 1'b0;
      core_rdata_blank_r <= 1'b0;
    end
    else
    begin
      core_grant_r       <= core_req & core_ok;
      core_deny_r        <= core_req & ~core_ok;
      core_rdata_blank_r <= core_req & (core_op == flash_guard_pkg::op_read)
                            & core_fence; // RULE_09
    end
  end

  // fetches and branches are never fenced, so callers can enter lower code
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      fetch_grant_r <= 1'b0;
    else
      fetch_grant_r <= fetch_req; // RULE_12
  end

  assign sfr_rdata        = sfr_rdata_r;
  assign dbg_grant        = dbg_grant_r;
  assign dbg_deny         = dbg_deny_r;
  assign dbg_full_erase   = dbg_full_erase_r;
  assign core_grant       = core_grant_r;
  assign core_deny        = core_deny_r;
  assign core_rdata_blank = core_rdata_blank_r;
  assign fetch_grant      = fetch_grant_r;
  assign read_time_code   = read_time_code_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_dbg_read_lock: assert property ( // RULE_02
    dbg_req && dbg_op == flash_guard_pkg::op_read && !dbg_lockbyte_hit && rd_in_map
    && !lock_rd_byte[dbg_addr[`REGION_HI:`REGION_LO]] |=> dbg_deny && !dbg_grant)
    else $error("debug read of read-locked region granted");
  chk_dbg_write_lock: assert property ( // RULE_03
    dbg_req && dbg_op != flash_guard_pkg::op_read && !dbg_lock_page && wr_in_map
    && !lock_wr_byte[dbg_addr[`REGION_HI:`REGION_LO]] |=> dbg_deny)
    else $error("debug write or erase of locked region granted");
  chk_top_erase_refuse: assert property ( // RULE_04
    dbg_req && dbg_op == flash_guard_pkg::op_erase && dbg_lock_page
    && !dbg_lockbyte_hit && !top_open |=> dbg_deny && !dbg_grant && !dbg_full_erase)
    else $error("lock page erased while top region locked");
  chk_limit_once: assert property ( // RULE_06
    limit_taken_r && sfr_wr && cpl_sel |=> $stable(code_protect_limit_r))
    else $error("access limit changed after first write");
  chk_limit_reset: assert property ( // RULE_08
    !limit_taken_r |-> partition_limit_address == {`ADDR_W{1'b0}})
    else $error("limit not zero before first write");
  chk_fenced_read: assert property ( // RULE_09
    core_req && core_op == flash_guard_pkg::op_read && core_pc >= partition_limit_address
    && core_addr < partition_limit_address |=> core_rdata_blank && core_deny)
    else $error("upper code read of lower partition returned data");
  chk_lower_free: assert property ( // RULE_10
    core_req && core_op == flash_guard_pkg::op_read && core_pc < partition_limit_address
    |=> core_grant && !core_rdata_blank)
    else $error("lower partition read refused");
  chk_we_allow: assert property ( // RULE_20
    core_req && core_op != flash_guard_pkg::op_read && !write_erase_allow_r |=> core_deny)
    else $error("firmware write or erase without allow bit");
  chk_lock_page_fw: assert property ( // RULE_14
    core_req && core_op == flash_guard_pkg::op_erase && core_lock_page |=> !core_grant)
    else $error("firmware erased lock byte page");
  chk_lockbyte_open: assert property ( // RULE_15
    dbg_req && dbg_lockbyte_hit && dbg_op != flash_guard_pkg::op_erase |=> dbg_grant)
    else $error("debug access to lock byte refused");
  chk_full_erase: assert property ( // RULE_23
    dbg_req && dbg_lockbyte_hit && dbg_op == flash_guard_pkg::op_erase
    |=> dbg_full_erase && dbg_grant ##1 !dbg_full_erase || $past(dbg_req))
    else $error("lock byte erase did not start full erase");
  chk_fw_no_full: assert property ( // RULE_23
    dbg_full_erase |-> $past(dbg_req) && $past(dbg_lockbyte_hit)
    && $past(dbg_op) == flash_guard_pkg::op_erase)
    else $error("full erase without debug request");
  chk_fetch_pass: assert property ( // RULE_12
    fetch_req |=> fetch_grant)
    else $error("instruction fetch refused");
  chk_rsvd_zero: assert property ( // RULE_21
    sfr_rd && twc_sel |=> sfr_rdata[`TWC_RSVD_HI:`TWC_RSVD_LO] == `TWC_RSVD_RD)
    else $error("reserved control bits read nonzero");

  cov_full_erase: cover property (dbg_req && dbg_full_nxt ##1 dbg_full_erase);
  cov_fenced: cover property (core_req && core_fence ##1 core_deny);
  cov_limit_set: cover property (sfr_wr && cpl_sel ##1 limit_taken_r);
  cov_lock_page_erase: cover property (dbg_req && dbg_lock_page && top_open
                                       && dbg_op == flash_guard_pkg::op_erase);

endmodule
`default_nettype wire

// ---- tb/access_model.sv ----
// behavioural core and debug-port model that issues flash guard requests
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_regs.svh"
module access_model (
  // clock
  input  wire logic                           clk_sys,
  // register port
  output logic [7:0]                          sfr_addr,
  output logic                                sfr_wr,
  output logic                                sfr_rd,
  output logic [7:0]                          sfr_wdata,
  // debug port
  output logic                                dbg_req,
  output var flash_guard_pkg::flash_op_e      dbg_op,
  output logic [`ADDR_W-1:0]                  dbg_addr,
  // firmware side
  output logic                                core_req,
  output var flash_guard_pkg::flash_op_e      core_op,
  output logic [`ADDR_W-1:0]                  core_addr,
  output logic [`ADDR_W-1:0]                  core_pc,
  output logic                                fetch_req
);
  // quiet bus at time zero
  initial
  begin
    {sfr_wr, sfr_rd, dbg_req, core_req, fetch_req} = 5'h00;
    {sfr_addr, sfr_wdata} = 16'h0000;
    {dbg_addr, core_addr, core_pc} = 51'h0;
    dbg_op = flash_guard_pkg::op_read;
    core_op = flash_guard_pkg::op_read;
  end

  // one register cycle; released lines show the inverse so nothing stale passes
  task automatic sfr_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `CPL_OFFSET) v[0] = 1'b0;
    if (a == `TWC_OFFSET) v[3:1] = 3'h0;
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= wr;
    sfr_rd    <= !wr;
    @(posedge clk_sys);
    {sfr_wr, sfr_rd} <= 2'h0;
    sfr_addr  <= ~a;
    sfr_wdata <= ~v;
  endtask

  // one debug-port request pulse
  task automatic dbg_access(input flash_guard_pkg::flash_op_e op, input logic [16:0] a);
    @(posedge clk_sys);
    dbg_req  <= 1'b1;
    dbg_op   <= op;
    dbg_addr <= a;
    @(posedge clk_sys);
    dbg_req  <= 1'b0;
    dbg_addr <= ~a;
  endtask

  // one firmware request, optionally with a fetch in the same cycle
  task automatic core_access(input flash_guard_pkg::flash_op_e op, input logic [16:0] a,
                             input logic [16:0] pc, input logic f);
    @(posedge clk_sys);
    core_req  <= 1'b1;
    core_op   <= op;
    core_addr <= a;
    core_pc   <= pc;
    fetch_req <= f;
    @(posedge clk_sys);
    {core_req, fetch_req} <= 2'h0;
    core_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the flash access guard
`timescale 1ns/1ns
`default_nettype none
`include "flash_guard_regs.svh"
module testbench;
  // clock, reset, stored lock bytes
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] lock_wr_byte = 8'hff;
  logic [7:0] lock_rd_byte = 8'hff;
  // request and answer lines
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic        sfr_wr, sfr_rd, dbg_req, core_req, fetch_req;
  logic [16:0] dbg_addr, core_addr, core_pc;
  logic        dbg_grant, dbg_deny, dbg_full_erase, fetch_grant;
  logic        core_grant, core_deny, core_rdata_blank;
  logic [1:0]  read_time_code;
  flash_guard_pkg::flash_op_e dbg_op, core_op;
  // expected register state and counters
  logic [7:0] exp_cpl = 8'h00;
  logic       exp_we = 1'b0;
  int         n_mismatch = 0;
  int         checks_done = 0;

  always #10 clk_sys = ~clk_sys;

  flash_access_guard flash_access_guard_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .lock_wr_byte(lock_wr_byte), .lock_rd_byte(lock_rd_byte),
    .dbg_req(dbg_req), .dbg_op(dbg_op), .dbg_addr(dbg_addr), .dbg_grant(dbg_grant),
    .dbg_deny(dbg_deny), .dbg_full_erase(dbg_full_erase), .core_req(core_req),
    .core_op(core_op), .core_addr(core_addr), .core_pc(core_pc), .core_grant(core_grant),
    .core_deny(core_deny), .core_rdata_blank(core_rdata_blank), .fetch_req(fetch_req),
    .fetch_grant(fetch_grant), .read_time_code(read_time_code));

  access_model access_model_i (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .dbg_req(dbg_req), .dbg_op(dbg_op),
    .dbg_addr(dbg_addr), .core_req(core_req), .core_op(core_op), .core_addr(core_addr),
    .core_pc(core_pc), .fetch_req(fetch_req));

  // expected {grant, deny, full erase, fetch} for a debug request
  function automatic logic [3:0] dbg_exp(logic [1:0] op, logic [16:0] a);
    logic ok;
    logic lb;
    lb = (a == `LOCK_WR_ADDR) || (a == `LOCK_RD_ADDR);
    if (a < `MAP_TOP_ADDR)
      ok = (op == 2'h0) ? lock_rd_byte[a[15:14]] : lock_wr_byte[a[15:14]];
    else if (lb)
      ok = 1'b1;
    else
      ok = (a[16:10] == `LOCK_PAGE_IDX) && (op != 2'h0) && lock_wr_byte[3];
    return {ok, !ok, ok && lb && (op == 2'h2), 1'b0};
  endfunction

  // expected {grant, deny, blank, fetch} for a firmware request
  function automatic logic [3:0] core_exp(logic [1:0] op, logic [16:0] a, logic [16:0] pc,
                                          logic f);
    logic fence;
    logic ok;
    fence = (pc >= {exp_cpl, 9'h000}) && (a < {exp_cpl, 9'h000});
    ok = !fence && (op == 2'h0 || exp_we) && !(op == 2'h2 && a[16:10] == `LOCK_PAGE_IDX);
    return {ok, !ok, fence && (op == 2'h0), f};
  endfunction

  task automatic cmp_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_resp(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // read a register and compare the returned byte
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    access_model_i.sfr_access(1'b0, a, 8'h00);
    #1;
    cmp_reg("sfr_rdata", exp, sfr_rdata);
  endtask

  // debug request, op 0 read 1 write 2 erase
  task automatic dchk(input logic [1:0] op, input logic [16:0] a);
    access_model_i.dbg_access(flash_guard_pkg::flash_op_e'(op), a);
    #1;
    cmp_resp("dbg verdict", dbg_exp(op, a), {dbg_grant, dbg_deny, dbg_full_erase, fetch_grant});
  endtask

  task automatic cchk(input logic [1:0] op, input logic [16:0] a, input logic [16:0] pc,
                      input logic f);
    access_model_i.core_access(flash_guard_pkg::flash_op_e'(op), a, pc, f);
    #1;
    cmp_resp("core verdict", core_exp(op, a, pc, f),
             {core_grant, core_deny, core_rdata_blank, fetch_grant});
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, far beyond the fewer than one thousand cycles the tests need
  initial
  begin
    #1000000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    logic [1:0] op;
    void'($urandom(65));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk(8'hb7, 8'h80);
    rchk(8'hb6, 8'h00);
    rchk(8'h55, 8'h00);
    cchk(2'h0, 17'h00100, 17'h09000, 1'b0);
    // every read-time code, allow bit toggling, reserved bits forced clear
    for (int i = 0; i < 4; i++)
    begin
      exp_we = i[0];
      // unused top bits written as ones must still read back as their reset value
      access_model_i.sfr_access(1'b1, 8'hb7, {2'h3, i[1:0], 3'h7, 1'b1} ^ {7'h0, !exp_we});
      rchk(8'hb7, {2'h2, i[1:0], 3'h0, exp_we});
      cmp_reg("read_time_code", {6'h0, i[1:0]}, {6'h0, read_time_code});
      cchk(2'h1, 17'h02000, 17'h00000, 1'b1);
    end
    // firmware has cache and prefetch held off here, so dropping the read time is safe
    access_model_i.sfr_access(1'b1, 8'hb7, 8'h11);
    exp_we = 1'b1;
    // limit takes only the first write
    access_model_i.sfr_access(1'b1, 8'hb6, 8'h40);
    exp_cpl = 8'h40;
    access_model_i.sfr_access(1'b1, 8'hb6, 8'h80);
    rchk(8'hb6, 8'h40);
    cchk(2'h0, 17'h07fff, 17'h08000, 1'b1);
    cchk(2'h0, 17'h08000, 17'h08000, 1'b0);
    cchk(2'h1, 17'h00100, 17'h07ffe, 1'b0);
    cchk(2'h2, 17'h00400, 17'h0c000, 1'b1);
    cchk(2'h2, 17'h1fbfe, 17'h00000, 1'b0);
    cchk(2'h1, 17'h1fbff, 17'h0c000, 1'b0);
    // region 3 and region 0 locked against the debug port
    @(posedge clk_sys);
    lock_wr_byte <= 8'hf7;
    lock_rd_byte <= 8'hfe;
    cchk(2'h1, 17'h0c100, 17'h00000, 1'b0);
    dchk(2'h0, 17'h00100);
    dchk(2'h0, 17'h04000);
    dchk(2'h1, 17'h0ffff);
    dchk(2'h2, 17'h0c000);
    dchk(2'h1, 17'h1fbfe);
    dchk(2'h0, 17'h1fbff);
    dchk(2'h2, 17'h1f800);
    dchk(2'h2, 17'h1fbfe);
    dchk(2'h0, 17'h14000);
    @(posedge clk_sys);
    lock_wr_byte <= 8'hff;
    dchk(2'h2, 17'h1f800);
    dchk(2'h2, 17'h1fbff);
    // random traffic under random lock bytes and pc on both sides of the limit
    for (int i = 0; i < 150; i++)
    begin
      @(posedge clk_sys);
      lock_wr_byte <= 8'($urandom);
      lock_rd_byte <= 8'($urandom);
      op = 2'($urandom % 3);
      dchk(op, 17'($urandom % 32'h10000));
      cchk(op, 17'($urandom), 17'($urandom), 1'($urandom));
    end
    // a second reset reopens the limit register for one write
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    exp_cpl = 8'h20;
    exp_we = 1'b0;
    access_model_i.sfr_access(1'b1, 8'hb6, 8'h20);
    rchk(8'hb6, 8'h20);
    rchk(8'hb7, 8'h80);
    cchk(2'h1, 17'h04000, 17'h04000, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
